// >>> design/tape_sense_pkg.sv
// Purpose: Shared constants and carriers for the tape sense status report block.
// Assumes: Sense bytes travel MSB-first with bit 0 as the most significant bit.
// Notes:   Reject codes are six bits wide; most imply the incomplete flag.
package tape_sense_pkg;

  // ----------------------------------------------------------------------
  // Transfer shape
  // ----------------------------------------------------------------------
  localparam int unsigned SHORT_SENSE_LEN    = 8;
  localparam int unsigned EXT_SENSE_LEN      = 32;
  localparam int unsigned STROBE_HIGH_CYCLES = 2;
  localparam int unsigned STROBE_LOW_CYCLES  = 2;

  // ----------------------------------------------------------------------
  // Byte positions within the short sense record
  // ----------------------------------------------------------------------
  localparam logic [4:0] IDX_HARD_RW     = 5'h03;
  localparam logic [4:0] IDX_HARD_CONT   = 5'h04;
  localparam logic [4:0] IDX_REJECT      = 5'h05;
  localparam logic [4:0] IDX_CORRECTED   = 5'h06;
  localparam logic [4:0] IDX_DEAD_TRACK  = 5'h07;

  // Byte positions within the extended record.
  localparam logic [4:0] XIDX_MODE       = 5'h00;
  localparam logic [4:0] XIDX_RETRY      = 5'h01;
  localparam logic [4:0] XIDX_BUF_COUNT  = 5'h02;
  localparam logic [4:0] XIDX_REC_HI     = 5'h03;
  localparam logic [4:0] XIDX_REC_MID    = 5'h04;
  localparam logic [4:0] XIDX_REC_LO     = 5'h05;
  localparam logic [4:0] XIDX_DEAD_FIRST = 5'h06;
  localparam logic [4:0] XIDX_FIRST_ERR  = 5'h07;
  localparam logic [4:0] XIDX_FIRST_RW   = 5'h08;
  localparam logic [4:0] XIDX_DIAG_AID   = 5'h09;

  // ----------------------------------------------------------------------
  // Reject codes
  // ----------------------------------------------------------------------
  localparam logic [5:0] RJ_NONE            = 6'h00;
  localparam logic [5:0] RJ_NOT_READY       = 6'h01;
  localparam logic [5:0] RJ_FILE_PROTECT    = 6'h05;
  localparam logic [5:0] RJ_NO_ERASE        = 6'h06;
  localparam logic [5:0] RJ_ILLEGAL_SEQ     = 6'h07;
  localparam logic [5:0] RJ_NO_READ         = 6'h08;
  localparam logic [5:0] RJ_ID_BURST        = 6'h09;
  localparam logic [5:0] RJ_NO_WRITE        = 6'h0C;
  localparam logic [5:0] RJ_NOISE           = 6'h0F;
  localparam logic [5:0] RJ_CACHE_EMPTY     = 6'h10;
  localparam logic [5:0] RJ_DROPPED_READY   = 6'h11;
  localparam logic [5:0] RJ_AT_BOT          = 6'h13;
  localparam logic [5:0] RJ_LONG_GAP        = 6'h15;
  localparam logic [5:0] RJ_SPEED_TWICE     = 6'h16;
  localparam logic [5:0] RJ_WRONG_DENSITY   = 6'h18;
  localparam logic [5:0] RJ_GAP_DATA        = 6'h1B;
  localparam logic [5:0] RJ_LOST_RECORD     = 6'h1D;
  localparam logic [5:0] RJ_CAL_UNREADABLE  = 6'h1E;
  localparam logic [5:0] RJ_NO_VERIFY_DATA  = 6'h1F;

  // Set bits mark codes that also raise operation incomplete (all starred codes).
  localparam logic [63:0] INCOMPLETE_MAP = 64'h0000_0000_ED33_934C;

  // ----------------------------------------------------------------------
  // Gap limits in feet and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned GAP_LIMIT_PE_FEET  = 25;
  localparam int unsigned GAP_LIMIT_GCR_FEET = 15;
  localparam logic [7:0]  RESET_BYTE         = 8'h00;
  localparam logic [23:0] RESET_RECORD       = 24'h00_0000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // Hard error flags in transfer order, first field is bit 0 (MSB).
  typedef struct packed {
    logic tape_mark_write_check;
    logic uncorrectable_error_flag;
    logic partial_record;
    logic multi_track_error_flag;
    logic end_of_data_check_flag;
    logic velocity_error;
    logic crc_error;
    logic bot_before_backward;
    logic pe_write_single_track;
    logic transfer_parity_flag;
    logic overrun;
  } hard_error_type;

  // Detected reject conditions from the command sequencer.
  typedef struct packed {
    logic not_ready;
    logic file_protect_write;
    logic no_erase_status;
    logic illegal_sequence;
    logic no_read_status;
    logic id_burst_unreadable;
    logic no_write_status;
    logic signal_in_gap;
    logic cache_read_empty;
    logic ready_dropped;
    logic backward_at_bot;
    logic speed_change_twice;
    logic wrong_density;
    logic data_in_gap;
    logic lost_written_record;
    logic calibration_unreadable;
    logic no_verify_data;
  } reject_cause_type;

  typedef enum logic [1:0] {
    GAP_NONE = 2'b00,
    GAP_NOM  = 2'b01,
    GAP_P3   = 2'b11,
    GAP_P6   = 2'b10
  } gap_sel_type;

  typedef enum logic [1:0] {
    XF_IDLE  = 2'b00,
    XF_LOAD  = 2'b01,
    XF_HIGH  = 2'b11,
    XF_LOW   = 2'b10
  } xfer_state_type;

endpackage : tape_sense_pkg

// >>> design/tape_sense_status_report.sv
// Purpose: Builds sense status bytes and sends them over the read bus.
// Assumes: Event inputs are one-cycle pulses from logic on clk_sys_i.
// Notes:   Flags are sticky until a short or extended sense transfer ends.
`timescale 1ns/1ns
module tape_sense_status_report
  import tape_sense_pkg::*;
#(
  parameter int unsigned CLK_HZ = 10_000_000
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             sense_req_i,
  input  wire logic             ext_sense_req_i,
  input  wire hard_error_type   hard_err_i,
  input  wire reject_cause_type reject_i,
  input  wire logic             diag_mode_i,
  input  wire logic [2:0]       corrected_i,
  input  wire logic             gap_select_i,
  input  wire gap_sel_type      gap_sel_i,
  input  wire logic [8:0]       dead_track_i,
  input  wire logic             gcr_mode_i,
  input  wire logic             interblock_gap_i,
  input  wire logic             cache_data_mode_i,
  input  wire logic             sync_mode_i,
  input  wire logic [7:0]       retry_info_i,
  input  wire logic [7:0]       buf_count_i,
  input  wire logic [7:0]       sense_byte0_i,
  input  wire logic [7:0]       sense_byte1_i,
  input  wire logic [7:0]       sense_byte2_i,
  input  wire logic [7:0]       first_dead_i,
  input  wire logic [7:0]       first_err_i,
  input  wire logic [7:0]       first_rw_i,
  input  wire logic [7:0]       diag_aid_i,
  input  wire logic             record_err_i,
  input  wire logic [23:0]      record_num_i,
  output logic      [7:0]       read_bus_o,
  output logic                  read_parity_o,
  output logic                  read_strobe_o,
  output logic                  sense_busy_o,
  output logic                  hard_error_o,
  output logic                  corrected_error_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Bit 0 of the sense layout is the most significant bus bit.
  function automatic logic [7:0] msb_first(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[7 - i] = b[i];
    end
    return r;
  endfunction : msb_first

  function automatic logic odd_parity(input logic [7:0] b);
    return ~(^b);
  endfunction : odd_parity

  // Highest-priority reject cause wins; one code fits the byte.
  function automatic logic [5:0] reject_code(input reject_cause_type c);
    logic [5:0] r;
    r = RJ_NONE;
    if (c.not_ready)              r = RJ_NOT_READY;
    else if (c.ready_dropped)     r = RJ_DROPPED_READY;
    else if (c.file_protect_write) r = RJ_FILE_PROTECT;
    else if (c.illegal_sequence)  r = RJ_ILLEGAL_SEQ;
    else if (c.backward_at_bot)   r = RJ_AT_BOT;
    else if (c.speed_change_twice) r = RJ_SPEED_TWICE;
    else if (c.wrong_density)     r = RJ_WRONG_DENSITY;
    else if (c.no_erase_status)   r = RJ_NO_ERASE;
    else if (c.no_read_status)    r = RJ_NO_READ;
    else if (c.no_write_status)   r = RJ_NO_WRITE;
    else if (c.cache_read_empty)  r = RJ_CACHE_EMPTY;
    else if (c.signal_in_gap)     r = RJ_NOISE;
    else if (c.id_burst_unreadable) r = RJ_ID_BURST;
    else if (c.calibration_unreadable) r = RJ_CAL_UNREADABLE;
    else if (c.data_in_gap)       r = RJ_GAP_DATA;
    else if (c.no_verify_data)    r = RJ_NO_VERIFY_DATA;
    else if (c.lost_written_record) r = RJ_LOST_RECORD;
    return r;
  endfunction : reject_code

  // ----------------------------------------------------------------------
  // Interblock gap length watchdog
  // ----------------------------------------------------------------------
  // Tape runs at 100 inches per second at most, so one foot takes 120 ms.
  localparam int unsigned MS_PER_FOOT   = 120;
  localparam longint unsigned CYC_PER_MS = longint'(CLK_HZ) / 1000;
  localparam longint unsigned PE_CYC  = GAP_LIMIT_PE_FEET * MS_PER_FOOT * CYC_PER_MS;
  localparam longint unsigned GCR_CYC = GAP_LIMIT_GCR_FEET * MS_PER_FOOT * CYC_PER_MS;

  logic [31:0] gap_cnt_ff;
  logic        gap_long_ff;
  logic        in_gap;
  logic        long_gap_evt;

  // The sequencer holds interblock_gap_i high while a read or space passes a gap.
  // A wrap of the counter needs minutes in one gap, far past either limit.
  assign in_gap = interblock_gap_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !in_gap) begin
      gap_cnt_ff  <= 32'h0000_0000;
      gap_long_ff <= 1'b0;
    end else begin
      gap_cnt_ff  <= gap_cnt_ff + 32'h0000_0001;
      gap_long_ff <= (gcr_mode_i ? 64'(gap_cnt_ff) >= GCR_CYC
                                 : 64'(gap_cnt_ff) >= PE_CYC);
    end
  end

  assign long_gap_evt = gap_long_ff;

  // ----------------------------------------------------------------------
  // Sticky status bytes
  // ----------------------------------------------------------------------
  hard_error_type hard_ff;
  logic           reject_ff;
  logic           incomplete_ff;
  logic [5:0]     code_ff;
  logic [2:0]     corr_ff;
  gap_sel_type    gap_ff;
  logic [8:0]     dead_ff;
  logic [23:0]    rec_ff;
  logic           clear_evt;
  logic [5:0]     nxt_code;
  logic           new_reject;

  always_comb begin
    nxt_code = long_gap_evt ? RJ_LONG_GAP : reject_code(reject_i);
    new_reject = (nxt_code != RJ_NONE);
  end

  // Set beats clear: an event in the clearing cycle survives.
  // Only the first reject cause is kept, since later ones tend to hide the root cause.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hard_ff <= '0;
    end else begin
      hard_ff <= (clear_evt ? '0 : hard_ff) | hard_err_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      reject_ff     <= 1'b0;
      incomplete_ff <= 1'b0;
      code_ff       <= RJ_NONE;
    end else if (new_reject && code_ff == RJ_NONE || new_reject && clear_evt) begin
      reject_ff     <= 1'b1;
      code_ff       <= nxt_code;
      incomplete_ff <= INCOMPLETE_MAP[nxt_code];
    end else if (clear_evt) begin
      reject_ff     <= 1'b0;
      incomplete_ff <= 1'b0;
      code_ff       <= RJ_NONE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      corr_ff <= 3'b000;
    end else if (|corrected_i) begin
      corr_ff <= corrected_i;
    end else if (clear_evt) begin
      corr_ff <= 3'b000;
    end
  end

  // Gap choice persists; it describes the last extended write, not an error.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gap_ff <= GAP_NONE;
    end else if (gap_select_i) begin
      gap_ff <= gap_sel_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      dead_ff <= 9'h000;
    end else begin
      dead_ff <= (clear_evt ? 9'h000 : dead_ff) | dead_track_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rec_ff <= RESET_RECORD;
    end else if (record_err_i) begin
      rec_ff <= record_num_i;
    end
  end

  // ----------------------------------------------------------------------
  // Byte assembly, msb_first layouts written bit 7 first
  // ----------------------------------------------------------------------
  logic [7:0] byte3;
  logic [7:0] byte4;
  logic [7:0] byte5;
  logic [7:0] byte6;
  logic [7:0] byte7;

  always_comb begin
    byte3 = msb_first({hard_ff.crc_error, hard_ff.velocity_error,
                       hard_ff.end_of_data_check_flag, 1'b0,
                       hard_ff.multi_track_error_flag, hard_ff.partial_record,
                       hard_ff.uncorrectable_error_flag,
                       hard_ff.tape_mark_write_check});
    byte4 = msb_first({hard_ff.overrun, incomplete_ff, hard_ff.transfer_parity_flag,
                       reject_ff, 1'b0, hard_ff.pe_write_single_track, 1'b0,
                       hard_ff.bot_before_backward});
    byte5 = {diag_mode_i, 1'b0, code_ff};
    byte6 = msb_first({dead_ff[8], 1'b0, gap_ff == GAP_P6, gap_ff == GAP_P3,
                       gap_ff == GAP_NOM, corr_ff[2], corr_ff[1], corr_ff[0]});
    byte7 = msb_first(dead_ff[7:0]);
  end

  // ----------------------------------------------------------------------
  // Read bus sequencer
  // ----------------------------------------------------------------------
  xfer_state_type state_ff;
  logic           ext_ff;
  logic [4:0]     idx_ff;
  logic [1:0]     tick_ff;
  logic [7:0]     sel_byte;
  logic           last_byte;

  always_comb begin
    sel_byte = RESET_BYTE;
    if (!ext_ff) begin
      case (idx_ff)
        5'h00:          sel_byte = sense_byte0_i;
        5'h01:          sel_byte = sense_byte1_i;
        5'h02:          sel_byte = sense_byte2_i;
        IDX_HARD_RW:    sel_byte = byte3;
        IDX_HARD_CONT:  sel_byte = byte4;
        IDX_REJECT:     sel_byte = byte5;
        IDX_CORRECTED:  sel_byte = byte6;
        IDX_DEAD_TRACK: sel_byte = byte7;
        default:        sel_byte = RESET_BYTE;
      endcase
    end else begin
      case (idx_ff)
        XIDX_MODE:       sel_byte = {6'h00, cache_data_mode_i, sync_mode_i};
        XIDX_RETRY:      sel_byte = retry_info_i;
        XIDX_BUF_COUNT:  sel_byte = buf_count_i;
        XIDX_REC_HI:     sel_byte = rec_ff[23:16];
        XIDX_REC_MID:    sel_byte = rec_ff[15:8];
        XIDX_REC_LO:     sel_byte = rec_ff[7:0];
        XIDX_DEAD_FIRST: sel_byte = first_dead_i;
        XIDX_FIRST_ERR:  sel_byte = first_err_i;
        XIDX_FIRST_RW:   sel_byte = first_rw_i;
        XIDX_DIAG_AID:   sel_byte = diag_aid_i;
        default:         sel_byte = RESET_BYTE;
      endcase
    end
    last_byte = ext_ff ? (idx_ff == 5'(EXT_SENSE_LEN - 1))
                       : (idx_ff == 5'(SHORT_SENSE_LEN - 1));
  end

  // The load cycle follows the low phase, so strobes stand three low cycles apart.
  assign clear_evt = (state_ff == XF_LOW) && last_byte && (tick_ff == 2'b00);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_ff      <= XF_IDLE;
      ext_ff        <= 1'b0;
      idx_ff        <= 5'h00;
      tick_ff       <= 2'b00;
      read_bus_o    <= RESET_BYTE;
      read_parity_o <= 1'b0;
      read_strobe_o <= 1'b0;
      sense_busy_o  <= 1'b0;
    end else begin
      case (state_ff)
        XF_IDLE: begin
          if (sense_req_i || ext_sense_req_i) begin
            ext_ff       <= ext_sense_req_i && !sense_req_i;
            idx_ff       <= 5'h00;
            sense_busy_o <= 1'b1;
            state_ff     <= XF_LOAD;
          end
        end
        XF_LOAD: begin
          read_bus_o    <= sel_byte;
          read_parity_o <= odd_parity(sel_byte);
          tick_ff       <= 2'(STROBE_HIGH_CYCLES - 1);
          state_ff      <= XF_HIGH;
        end
        XF_HIGH: begin
          read_strobe_o <= 1'b1;
          if (tick_ff == 2'b00) begin
            tick_ff  <= 2'(STROBE_LOW_CYCLES - 1);
            state_ff <= XF_LOW;
          end else begin
            tick_ff <= tick_ff - 2'b01;
          end
        end
        XF_LOW: begin
          read_strobe_o <= 1'b0;
          if (tick_ff != 2'b00) begin
            tick_ff <= tick_ff - 2'b01;
          end else if (last_byte) begin
            sense_busy_o <= 1'b0;
            state_ff     <= XF_IDLE;
          end else begin
            idx_ff   <= idx_ff + 5'h01;
            state_ff <= XF_LOAD;
          end
        end
        default: state_ff <= XF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Status lines
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hard_error_o      <= 1'b0;
      corrected_error_o <= 1'b0;
    end else begin
      hard_error_o      <= (|byte3) || (|byte4);
      corrected_error_o <= |corr_ff;
    end
  end

endmodule : tape_sense_status_report

// >>> bench/tape_sense_status_report_assertions.sv
// Purpose: Timing and content checks on the sense read bus.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound onto every instance of the sense status block.
`timescale 1ns/1ns
module tape_sense_status_report_assertions
  import tape_sense_pkg::*;
(
  input wire logic             clk_sys_i,
  input wire logic             rst_n_i,
  input wire logic             sense_req_i,
  input wire logic             ext_sense_req_i,
  input wire hard_error_type   hard_err_i,
  input wire reject_cause_type reject_i,
  input wire logic [2:0]       corrected_i,
  input wire logic [7:0]       read_bus_o,
  input wire logic             read_parity_o,
  input wire logic             read_strobe_o,
  input wire logic             sense_busy_o,
  input wire logic             hard_error_o,
  input wire logic             corrected_error_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  logic [5:0] cnt_ff;
  logic       ext_ff;
  logic       stb_ff;
  logic       take;

  assign take = (sense_req_i || ext_sense_req_i) && !sense_busy_o;

  // Strobe rises are counted per transfer, so a short or long record shows at its end.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || take) begin
      cnt_ff <= 6'h00;
    end else if (read_strobe_o && !stb_ff) begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    stb_ff <= rst_n_i && read_strobe_o;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ext_ff <= 1'b0;
    end else if (take) begin
      ext_ff <= !sense_req_i;
    end
  end

  AST_HARD_ERR_RAISE:
    assert property (hard_err_i != '0 |-> ##[1:2] hard_error_o)
    else $error("hard error output missing after error flag");
  AST_REJECT_HARD:
    assert property (reject_i != '0 |-> ##[1:2] hard_error_o)
    else $error("hard error output missing after reject");
  AST_CORRECTED:
    assert property (corrected_i != 3'h0 |-> ##[1:2] corrected_error_o)
    else $error("corrected error output missing");
  AST_ODD_PARITY:
    assert property (read_strobe_o |-> ^{read_parity_o, read_bus_o})
    else $error("sense byte parity is not odd");
  AST_STROBE_SHAPE:
    assert property ($rose(read_strobe_o) |-> read_strobe_o[*2] ##1 !read_strobe_o[*2])
    else $error("strobe high or low phase has wrong width");
  AST_BUS_HELD:
    assert property (read_strobe_o |-> $stable(read_bus_o) && $stable(read_parity_o))
    else $error("read bus moved while strobe high");
  AST_STROBE_IN_BUSY:
    assert property (read_strobe_o |-> sense_busy_o)
    else $error("strobe outside a sense transfer");
  AST_BYTE_COUNT:
    assert property ($fell(sense_busy_o) |-> cnt_ff == (ext_ff ? 6'h20 : 6'h08))
    else $error("byte count of a sense transfer is wrong");
  AST_ANSWER_TIME:
    assert property (take |-> ##1 sense_busy_o ##2 $rose(read_strobe_o))
    else $error("first strobe not at the third cycle");

  cover property ($fell(sense_busy_o) && ext_ff);
  cover property ($fell(sense_busy_o) && !ext_ff);
  cover property ($rose(hard_error_o));
endmodule : tape_sense_status_report_assertions

bind tape_sense_status_report tape_sense_status_report_assertions i_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sense_req_i(sense_req_i),
  .ext_sense_req_i(ext_sense_req_i), .hard_err_i(hard_err_i), .reject_i(reject_i),
  .corrected_i(corrected_i), .read_bus_o(read_bus_o), .read_parity_o(read_parity_o),
  .read_strobe_o(read_strobe_o), .sense_busy_o(sense_busy_o),
  .hard_error_o(hard_error_o), .corrected_error_o(corrected_error_o));

// >>> bench/sense_host_model.sv
// Purpose: Host side of the read bus; collects each strobed sense byte.
// Assumes: A byte is valid on the rising strobe.
// Notes:   Bytes are kept as parity then data for the bench to compare.
`timescale 1ns/1ns
module sense_host_model (
  input wire logic       clk_i,
  input wire logic       strobe_i,
  input wire logic [7:0] bus_i,
  input wire logic       par_i
);
  logic [8:0] got_q [$];
  logic       prev_ff = 1'b0;

  always @(posedge clk_i) begin
    if (strobe_i && !prev_ff) begin
      got_q.push_back({par_i, bus_i});
    end
    prev_ff <= strobe_i;
  end
endmodule : sense_host_model

// >>> bench/tb.sv
// Purpose: Self-checking bench for the sense status report block.
// Assumes: Inputs change on the falling edge; events are one-cycle pulses.
// Notes:   Expected bytes come from a bench copy of the sticky state.
`timescale 1ns/1ns
module tb;
  import tape_sense_pkg::*;

  logic             clk, rst_n, sense_req, ext_req, diag, gap_stb, rec_stb;
  logic             gap_in, hard_line, corr_line;
  hard_error_type   hard_err;
  reject_cause_type reject;
  gap_sel_type      gap_sel, m_gap;
  logic [2:0]       corr, lvl, m_corr;
  logic [8:0]       dead, m_dead;
  logic [7:0]       raw [9];
  logic [23:0]      rec_num, m_rec;
  logic [7:0]       read_bus;
  logic             read_par, read_stb, busy;
  logic [10:0]      m_hard;
  logic [5:0]       m_rej;
  int               n_mismatch = 0;
  int               n_compared = 0;
  logic [31:0]      seed = 32'he1e9_bc5b;
  gap_sel_type      gaps [3] = '{GAP_NOM, GAP_P3, GAP_P6};
  logic [5:0]       codes [17] = '{6'h01, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0C, 6'h0F,
    6'h10, 6'h11, 6'h13, 6'h16, 6'h18, 6'h1B, 6'h1D, 6'h1E, 6'h1F};

  // A scaled rate brings the long gap limit within a short run.
  tape_sense_status_report #(.CLK_HZ(1_000)) i_dut (
    .clk_sys_i(clk), .rst_n_i(rst_n), .sense_req_i(sense_req), .ext_sense_req_i(ext_req),
    .hard_err_i(hard_err), .reject_i(reject), .diag_mode_i(diag), .corrected_i(corr),
    .gap_select_i(gap_stb), .gap_sel_i(gap_sel), .dead_track_i(dead), .gcr_mode_i(lvl[2]),
    .interblock_gap_i(gap_in),
    .cache_data_mode_i(lvl[1]), .sync_mode_i(lvl[0]), .retry_info_i(raw[0]),
    .buf_count_i(raw[1]), .sense_byte0_i(raw[2]), .sense_byte1_i(raw[3]),
    .sense_byte2_i(raw[4]), .first_dead_i(raw[5]), .first_err_i(raw[6]), .first_rw_i(raw[7]),
    .diag_aid_i(raw[8]), .record_err_i(rec_stb), .record_num_i(rec_num),
    .read_bus_o(read_bus), .read_parity_o(read_par), .read_strobe_o(read_stb),
    .sense_busy_o(busy), .hard_error_o(hard_line), .corrected_error_o(corr_line));

  sense_host_model i_host (.clk_i(clk), .strobe_i(read_stb), .bus_i(read_bus), .par_i(read_par));

  // --------------------------------------------------
  // Expectation helpers
  // --------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic star(input logic [5:0] c);
    case (c)
      6'h06, 6'h08, 6'h09, 6'h0C, 6'h0F, 6'h10, 6'h11: return 1'b1;
      6'h15, 6'h18, 6'h1B, 6'h1D, 6'h1E, 6'h1F: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : star

  // Bus bit 7 carries sense bit 0, so every field is laid out MSB-first.
  function automatic logic [7:0] exp_byte(input logic ext, input int k);
    logic [10:0] h;
    h = m_hard;
    if (ext) begin
      case (k)
        0: return {6'h00, lvl[1], lvl[0]};
        1, 2, 6, 7, 8, 9: return raw[k - 1];
        3: return m_rec[23:16];
        4: return m_rec[15:8];
        5: return m_rec[7:0];
        default: return 8'h00;
      endcase
    end
    case (k)
      3: return {h[10], h[9], h[8], h[7], 1'b0, h[6], h[5], h[4]};
      4: return {h[3], 1'b0, h[2], 1'b0, m_rej != 6'h00, h[1], star(m_rej), h[0]};
      5: return {diag, 1'b0, m_rej};
      6: return {m_corr[0], m_corr[1], m_corr[2], m_gap == GAP_NOM, m_gap == GAP_P3,
                 m_gap == GAP_P6, 1'b0, m_dead[8]};
      7: return {<<{m_dead[7:0]}};
      default: return raw[k + 2];
    endcase
  endfunction : exp_byte

  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t sense byte got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // --------------------------------------------------
  // Stimulus
  // --------------------------------------------------
  task automatic events(input logic [10:0] h, input logic [16:0] rj, input logic [2:0] c,
                        input logic [8:0] d, input logic g);
    hard_err = h;
    reject = rj;
    corr = c;
    dead = d;
    gap_stb = g;
    rec_stb = g;
    @(negedge clk);
    hard_err = '0;
    reject = '0;
    corr = 3'h0;
    dead = 9'h000;
    gap_stb = 1'b0;
    rec_stb = 1'b0;
    m_hard |= h;
    m_dead |= d;
    if (c != 3'h0) m_corr = c;
    if (g) m_gap = gap_sel;
    if (g) m_rec = rec_num;
    for (int j = 0; j < 17; j++) if (rj[16 - j] && m_rej == 6'h00) m_rej = codes[j];
  endtask : events

  // A second request in mid-transfer must be ignored without disturbing the count.
  task automatic do_sense(input logic ext, input logic dup);
    logic [7:0] e;
    int         n;
    int         len;
    i_host.got_q.delete();
    len = ext ? 32 : 8;
    if (ext) ext_req = 1'b1;
    else sense_req = 1'b1;
    @(negedge clk);
    sense_req = 1'b0;
    ext_req = 1'b0;
    check(9'(hard_line), 9'(m_hard != 11'h000 || m_rej != 6'h00));
    check(9'(corr_line), 9'(m_corr != 3'h0));
    repeat (3) @(negedge clk);
    sense_req = dup;
    @(negedge clk);
    sense_req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    if (n >= 400) n_mismatch++;
    check(9'(i_host.got_q.size()), 9'(len));
    for (int k = 0; k < len; k++) begin
      e = exp_byte(ext, k);
      check(i_host.got_q[k], {~^e, e});
    end
    m_hard = 11'h000;
    m_rej = 6'h00;
    m_corr = 3'h0;
    m_dead = 9'h000;
  endtask : do_sense

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end

  initial begin
    {rst_n, sense_req, ext_req, diag, gap_stb, rec_stb, corr, lvl, dead, gap_in} = 22'h0;
    {hard_err, reject, rec_num, m_rec, m_hard, m_rej, m_corr, m_dead} = 105'h0;
    gap_sel = GAP_NOM;
    m_gap = GAP_NONE;
    foreach (raw[k]) raw[k] = 8'h00;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    do_sense(1'b0, 1'b0);
    do_sense(1'b1, 1'b0);
    for (int i = 0; i < 17; i++) begin
      events(11'h000, 17'h1_0000 >> i, 3'h0, 9'h000, 1'b0);
      do_sense(1'b0, i == 3);
    end
    events(11'h000, 17'h1_0000, 3'h0, 9'h000, 1'b0);
    events(11'h000, 17'h0_0001, 3'h0, 9'h000, 1'b0);
    do_sense(1'b0, 1'b0);
    // A gap past the group-coded limit must leave code 15 behind.
    lvl = 3'h4;
    gap_in = 1'b1;
    repeat (1900) @(negedge clk);
    gap_in = 1'b0;
    m_rej = 6'h15;
    do_sense(1'b0, 1'b0);
    for (int r = 0; r < 16; r++) begin
      {diag, lvl} = 4'(rnd());
      foreach (raw[k]) raw[k] = 8'(rnd());
      gap_sel = gaps[rnd() % 3];
      rec_num = 24'(rnd());
      events(11'(rnd()), 17'h1_0000 >> (rnd() % 20), 3'h1 << (rnd() % 4), 9'(rnd()), 1'b1);
      do_sense(r[0], 1'b0);
    end
    complete_run();
  end
endmodule : tb
